// ===== core/fcrc_defs.svh
// Constants shared by both ends of the flash CRC check link
`ifndef FCRC_DEFS_SVH
`define FCRC_DEFS_SVH

// CRC parameters
`define FCRC_POLY 32'h1EDC_6F41
`define FCRC_INIT 32'hFFFF_FFFF
`define FCRC_XOROUT 32'hFFFF_FFFF
`define FCRC_MIN_SPAN 33'h0_0000_0003

// Array geometry
`define FCRC_AW 8
`define FCRC_DEPTH 256

// Command opcodes
`define FCRC_OP_CHECK 8'h5B
`define FCRC_OP_SUSP 8'hB0
`define FCRC_OP_RESUME 8'h30
`define FCRC_OP_RDREG 8'h65
`define FCRC_OP_RDARR 8'h13
`define FCRC_OP_SWRST 8'hF0

// Command framing, in bytes counted from the opcode
`define FCRC_ADDR_LAST 4'h4
`define FCRC_DATA_FIRST 4'h5
`define FCRC_CHECK_LEN 4'h9
`define FCRC_BYTEC_MAX 4'hF

// Device register addresses for the read register command
`define FCRC_RA_STS1 32'h0000_0000
`define FCRC_RA_STS2 32'h0000_0001
`define FCRC_RA_CRC0 32'h0000_0002
`define FCRC_RA_CRC1 32'h0000_0003
`define FCRC_RA_CRC2 32'h0000_0004
`define FCRC_RA_CRC3 32'h0000_0005

// Status bit positions
`define FCRC_RDY_BIT 0
`define FCRC_SUSP_BIT 4
`define FCRC_ABRT_BIT 3

// Serial clock timing
`define FCRC_HCLK_NS 8
`define FCRC_SCK_HALF_NS 64
`define FCRC_SCK_HALF_CYC (`FCRC_SCK_HALF_NS / `FCRC_HCLK_NS)

// Host register offsets
`define FCRC_A_CMD 8'h00
`define FCRC_A_TXLO 8'h04
`define FCRC_A_TXHI 8'h08
`define FCRC_A_RX 8'h0C
`define FCRC_A_STAT 8'h10
`define FCRC_A_IRQST 8'h14
`define FCRC_A_IRQCLR 8'h18
`define FCRC_A_IRQEN 8'h1C

// Host command register fields and event bits
`define FCRC_CMD_OP 7:0
`define FCRC_CMD_NTX 11:8
`define FCRC_CMD_NRX 15:12
`define FCRC_EV_DONE 0
`define FCRC_EV_SHORT 1
`define FCRC_MIN_GAP 32'h0000_0004

`endif

// ===== core/fcrc_pkg.sv
// Types shared by both ends of the flash CRC check link
package fcrc_pkg;

    typedef enum logic [1:0] {
        FCRC_ENG_IDLE,
        FCRC_ENG_RUN,
        FCRC_ENG_SUSP
    } fcrc_eng_t;

    typedef enum logic [1:0] {
        FCRC_H_IDLE,
        FCRC_H_LOW,
        FCRC_H_HIGH,
        FCRC_H_TAIL
    } fcrc_hst_t;

endpackage

// ===== core/fcrc_spi_if.sv
// Serial link between the flash device end and its host controller
`timescale 1ns/1ps
interface fcrc_spi_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;

    modport dev (
        input sck,
        input cs_n,
        input mosi,
        output miso
    );

    modport host (
        output sck,
        output cs_n,
        output mosi,
        input miso
    );
endinterface

// ===== core/fcrc_device.sv
// Device end: serial command decoder and CRC range engine over the array
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "fcrc_defs.svh"
module fcrc_device (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Serial link
    fcrc_spi_if.dev spi,
    // Array preload
    input wire logic arr_wr_en,
    input wire logic [`FCRC_AW-1:0] arr_wr_addr,
    input wire logic [7:0] arr_wr_data,
    // Status
    output logic busy,
    output logic suspended,
    output logic aborted
);
    import fcrc_pkg::*;

    typedef struct packed {
        logic [`FCRC_DEPTH-1:0][7:0] mem;
        logic sck_m;
        logic sck_s;
        logic sck_d;
        logic cs_m;
        logic cs_s;
        logic cs_d;
        logic mosi_m;
        logic mosi_s;
        logic [7:0] in_sr;
        logic [2:0] bitc;
        logic [3:0] bytec;
        logic [7:0] op;
        logic [31:0] stage;
        logic [31:0] ptr;
        logic pend_load;
        logic [7:0] out_sr;
        logic [31:0] range_start_address;
        logic [31:0] range_end_address;
        logic [31:0] cur;
        logic [2:0] cbit;
        logic [31:0] crc;
        logic [31:0] crc_check_value;
        fcrc_eng_t eng;
        logic busy;
        logic susp;
        logic abrt;
    } fcrc_dev_st_t;

    fcrc_dev_st_t st_ff;
    fcrc_dev_st_t nxt_st;

    // Register byte seen by the read register command
    function automatic logic [7:0] fcrc_reg_byte(input fcrc_dev_st_t s);
        logic [7:0] b;
        b = '0;
        case (s.ptr)
            `FCRC_RA_STS1: b[`FCRC_RDY_BIT] = s.busy;
            `FCRC_RA_STS2:
            begin
                b[`FCRC_SUSP_BIT] = s.susp;
                b[`FCRC_ABRT_BIT] = s.abrt;
            end
            `FCRC_RA_CRC0: b = s.crc_check_value[7:0];
            `FCRC_RA_CRC1: b = s.crc_check_value[15:8];
            `FCRC_RA_CRC2: b = s.crc_check_value[23:16];
            `FCRC_RA_CRC3: b = s.crc_check_value[31:24];
            default: b = '0;
        endcase
        return b;
    endfunction

    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic [7:0] in_byte;
    logic [7:0] eng_data;
    logic fb;
    logic [31:0] crc_nx;
    logic range_bad;

    always_comb
    begin
        nxt_st = st_ff;
        // Link pins are asynchronous to hclk
        nxt_st.sck_m = spi.sck;
        nxt_st.sck_s = st_ff.sck_m;
        nxt_st.sck_d = st_ff.sck_s;
        nxt_st.cs_m = spi.cs_n;
        nxt_st.cs_s = st_ff.cs_m;
        nxt_st.cs_d = st_ff.cs_s;
        nxt_st.mosi_m = spi.mosi;
        nxt_st.mosi_s = st_ff.mosi_m;
        sck_rise = st_ff.sck_s & ~st_ff.sck_d;
        sck_fall = ~st_ff.sck_s & st_ff.sck_d;
        cs_rise = st_ff.cs_s & ~st_ff.cs_d;
        in_byte = {st_ff.in_sr[6:0], st_ff.mosi_s};

        if (arr_wr_en)
            nxt_st.mem[arr_wr_addr] = arr_wr_data;

        // One array bit per cycle, MSB first, no reflection
        eng_data = st_ff.mem[st_ff.cur[`FCRC_AW-1:0]];
        fb = st_ff.crc[31] ^ eng_data[~st_ff.cbit];
        crc_nx = {st_ff.crc[30:0], 1'b0} ^ (fb ? `FCRC_POLY : '0);
        if (st_ff.eng == FCRC_ENG_RUN)
        begin
            nxt_st.crc = crc_nx;
            nxt_st.cbit = st_ff.cbit + 3'h1;
            if (st_ff.cbit == 3'h7)
            begin
                if (st_ff.cur == st_ff.range_end_address)
                begin
                    nxt_st.crc_check_value = crc_nx ^ `FCRC_XOROUT;
                    nxt_st.eng = FCRC_ENG_IDLE;
                    nxt_st.busy = 1'b0;
                end
                else
                    nxt_st.cur = st_ff.cur + 32'h0000_0001;
            end
        end

        // Serial shift logic, mode 0
        if (st_ff.cs_s)
        begin
            nxt_st.bitc = '0;
            nxt_st.bytec = '0;
            nxt_st.pend_load = 1'b0;
        end
        else if (sck_rise)
        begin
            nxt_st.in_sr = in_byte;
            nxt_st.bitc = st_ff.bitc + 3'h1;
            if (st_ff.bitc == 3'h7)
            begin
                nxt_st.pend_load = 1'b1;
                if (st_ff.bytec != `FCRC_BYTEC_MAX)
                    nxt_st.bytec = st_ff.bytec + 4'h1;
                if (st_ff.bytec == '0)
                    nxt_st.op = in_byte;
                else
                    nxt_st.stage = {st_ff.stage[23:0], in_byte};
                if (st_ff.bytec == `FCRC_ADDR_LAST)
                    nxt_st.ptr = {st_ff.stage[23:0], in_byte};
            end
        end
        else if (sck_fall)
        begin
            if (st_ff.pend_load)
            begin
                // First bit of each byte must be out before the next rise
                nxt_st.pend_load = 1'b0;
                nxt_st.out_sr = '0;
                if (st_ff.bytec >= `FCRC_DATA_FIRST)
                begin
                    if (st_ff.op == `FCRC_OP_RDARR)
                    begin
                        nxt_st.out_sr = st_ff.mem[st_ff.ptr[`FCRC_AW-1:0]];
                        nxt_st.ptr = st_ff.ptr + 32'h0000_0001;
                    end
                    else if (st_ff.op == `FCRC_OP_RDREG)
                    begin
                        nxt_st.out_sr = fcrc_reg_byte(st_ff);
                        nxt_st.ptr = st_ff.ptr + 32'h0000_0001;
                    end
                end
            end
            else
                nxt_st.out_sr = {st_ff.out_sr[6:0], 1'b0};
        end

        // Commands act only once chip select is released
        range_bad = {1'b0, st_ff.stage} < ({1'b0, st_ff.ptr} + `FCRC_MIN_SPAN);
        if (cs_rise && (st_ff.bitc == '0))
        begin
            case (st_ff.op)
                `FCRC_OP_CHECK:
                begin
                    // Ignored unless in standby with a full frame
                    if ((st_ff.bytec >= `FCRC_CHECK_LEN) && (nxt_st.eng == FCRC_ENG_IDLE))
                    begin
                        nxt_st.range_start_address = st_ff.ptr;
                        nxt_st.range_end_address = st_ff.stage;
                        if (range_bad)
                        begin
                            // Check-value is left as is and is not meaningful
                            nxt_st.abrt = 1'b1;
                            nxt_st.busy = 1'b0;
                        end
                        else
                        begin
                            nxt_st.abrt = 1'b0;
                            nxt_st.eng = FCRC_ENG_RUN;
                            nxt_st.busy = 1'b1;
                            nxt_st.cur = st_ff.ptr;
                            nxt_st.cbit = '0;
                            nxt_st.crc = `FCRC_INIT;
                        end
                    end
                end
                `FCRC_OP_SUSP:
                begin
                    // Applies to whichever embedded operation is active
                    if (nxt_st.eng == FCRC_ENG_RUN)
                    begin
                        nxt_st.eng = FCRC_ENG_SUSP;
                        nxt_st.susp = 1'b1;
                        nxt_st.busy = 1'b0;
                    end
                end
                `FCRC_OP_RESUME:
                begin
                    if (st_ff.eng == FCRC_ENG_SUSP)
                    begin
                        nxt_st.eng = FCRC_ENG_RUN;
                        nxt_st.susp = 1'b0;
                        nxt_st.busy = 1'b1;
                    end
                end
                `FCRC_OP_SWRST:
                begin
                    nxt_st.eng = FCRC_ENG_IDLE;
                    nxt_st.busy = 1'b0;
                    nxt_st.susp = 1'b0;
                    nxt_st.abrt = 1'b0;
                end
                default: nxt_st.eng = nxt_st.eng;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '{cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1, eng: FCRC_ENG_IDLE, default: '0};
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
        end
    end

    assign spi.miso = st_ff.out_sr[7];
    assign busy = st_ff.busy;
    assign suspended = st_ff.susp;
    assign aborted = st_ff.abrt;

endmodule

// ===== core/fcrc_host.sv
// Host end: AHB-Lite register slave driving serial command frames
`timescale 1ns/1ps
`include "fcrc_defs.svh"
module fcrc_host (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt
    output logic irq,
    // Serial link
    fcrc_spi_if.host spi
);
    import fcrc_pkg::*;

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [15:0] cmd;
        logic [31:0] txlo;
        logic [31:0] txhi;
        logic [31:0] rx;
        logic [1:0] irq_st;
        logic [1:0] irq_en;
        logic [31:0] rdata;
        logic rdy;
        logic irq;
        fcrc_hst_t state;
        logic [3:0] ph;
        logic [7:0] bits;
        logic [71:0] tx_sr;
        logic sck;
        logic cs_n;
        logic mosi;
        logic miso_m;
        logic miso_s;
    } fcrc_hst_st_t;

    fcrc_hst_st_t st_ff;
    fcrc_hst_st_t nxt_st;

    logic go;
    logic ph_end;
    logic [1:0] ev;
    logic [1:0] clr;
    logic [4:0] nbytes;

    always_comb
    begin
        nxt_st = st_ff;
        go = 1'b0;
        ev = '0;
        clr = '0;
        nbytes = '0;
        nxt_st.miso_m = spi.miso;
        nxt_st.miso_s = st_ff.miso_m;
        nxt_st.rdy = 1'b1;

        // Data phase of a write taken in the previous cycle
        if (st_ff.wr_pend)
        begin
            nxt_st.wr_pend = 1'b0;
            case (st_ff.wr_addr)
                `FCRC_A_CMD:
                begin
                    // A command write while a frame is still running is dropped
                    if (st_ff.state == FCRC_H_IDLE)
                    begin
                        nxt_st.cmd = hwdata[15:0];
                        go = 1'b1;
                    end
                end
                `FCRC_A_TXLO: nxt_st.txlo = hwdata;
                `FCRC_A_TXHI: nxt_st.txhi = hwdata;
                `FCRC_A_IRQCLR: clr = hwdata[1:0];
                `FCRC_A_IRQEN: nxt_st.irq_en = hwdata[1:0];
                default: nxt_st.wr_pend = 1'b0;
            endcase
        end

        // Frame engine
        ph_end = (st_ff.ph == 4'(`FCRC_SCK_HALF_CYC - 1));
        nxt_st.ph = ph_end ? '0 : st_ff.ph + 4'h1;
        case (st_ff.state)
            FCRC_H_IDLE:
            begin
                nxt_st.ph = '0;
                if (go)
                begin
                    nbytes = 5'h01 + {1'b0, hwdata[`FCRC_CMD_NTX]} + {1'b0, hwdata[`FCRC_CMD_NRX]};
                    nxt_st.bits = {nbytes, 3'h0};
                    // Opcode, then both range words, most significant first
                    nxt_st.tx_sr = {hwdata[`FCRC_CMD_OP], st_ff.txlo, st_ff.txhi};
                    nxt_st.cs_n = 1'b0;
                    nxt_st.state = FCRC_H_LOW;
                    if ((hwdata[`FCRC_CMD_OP] == `FCRC_OP_CHECK)
                        && ({1'b0, st_ff.txhi} < ({1'b0, st_ff.txlo} + {1'b0, `FCRC_MIN_GAP})))
                    begin
                        ev[`FCRC_EV_SHORT] = 1'b1;
                    end
                end
            end
            FCRC_H_LOW:
            begin
                if (ph_end)
                begin
                    if (st_ff.bits == '0)
                    begin
                        nxt_st.cs_n = 1'b1;
                        nxt_st.state = FCRC_H_TAIL;
                    end
                    else
                    begin
                        nxt_st.sck = 1'b1;
                        nxt_st.rx = {st_ff.rx[30:0], st_ff.miso_s};
                        nxt_st.state = FCRC_H_HIGH;
                    end
                end
            end
            FCRC_H_HIGH:
            begin
                if (ph_end)
                begin
                    nxt_st.sck = 1'b0;
                    nxt_st.tx_sr = {st_ff.tx_sr[70:0], 1'b0};
                    nxt_st.bits = st_ff.bits - 8'h01;
                    nxt_st.state = FCRC_H_LOW;
                end
            end
            FCRC_H_TAIL:
            begin
                // Keeps chip select high one half period between frames
                if (ph_end)
                begin
                    ev[`FCRC_EV_DONE] = 1'b1;
                    nxt_st.state = FCRC_H_IDLE;
                end
            end
            default: nxt_st.state = FCRC_H_IDLE;
        endcase
        nxt_st.mosi = nxt_st.tx_sr[71];

        // A new event wins over a clear in the same cycle
        nxt_st.irq_st = (st_ff.irq_st & ~clr) | ev;
        nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_en);

        // Address phase; reads see writes that land this cycle
        if (hsel && htrans[1] && hready)
        begin
            if (hwrite)
            begin
                nxt_st.wr_pend = 1'b1;
                nxt_st.wr_addr = haddr[7:0];
            end
            else
            begin
                case (haddr[7:0])
                    `FCRC_A_CMD: nxt_st.rdata = {16'h0000, nxt_st.cmd};
                    `FCRC_A_TXLO: nxt_st.rdata = nxt_st.txlo;
                    `FCRC_A_TXHI: nxt_st.rdata = nxt_st.txhi;
                    `FCRC_A_RX: nxt_st.rdata = nxt_st.rx;
                    `FCRC_A_STAT: nxt_st.rdata = {31'h0000_0000, nxt_st.state != FCRC_H_IDLE};
                    `FCRC_A_IRQST: nxt_st.rdata = {30'h0000_0000, nxt_st.irq_st};
                    `FCRC_A_IRQEN: nxt_st.rdata = {30'h0000_0000, nxt_st.irq_en};
                    default: nxt_st.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '{state: FCRC_H_IDLE, cs_n: 1'b1, default: '0};
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
        end
    end

    assign hrdata = st_ff.rdata;
    assign hreadyout = st_ff.rdy;
    assign hresp = 1'b0;
    assign irq = st_ff.irq;
    assign spi.sck = st_ff.sck;
    assign spi.cs_n = st_ff.cs_n;
    assign spi.mosi = st_ff.mosi;

endmodule

// ===== tb/fcrc_assertions.sv
// Concurrent checks on the serial link and the device status flags
`timescale 1ns/1ps
module fcrc_assertions (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    // Device status
    input wire logic busy,
    input wire logic suspended,
    input wire logic aborted
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Commands act only once chip select has been high for a while
    sequence s_cs_settled;
        cs_n && $past(cs_n, 2);
    endsequence
    sequence s_sck_pulse;
        sck [*8] ##1 !sck;
    endsequence

    property p_start_at_cs;
        $rose(busy) |-> s_cs_settled;
    endproperty
    property p_busy_susp;
        !(busy && suspended);
    endproperty
    property p_susp_from_run;
        $rose(suspended) |-> $past(busy);
    endproperty
    property p_resume_at_cs;
        $fell(suspended) |-> s_cs_settled ##[0:4] busy;
    endproperty
    property p_abort_idle;
        $rose(aborted) |-> !busy && !suspended ##0 s_cs_settled;
    endproperty
    property p_abort_sticky;
        aborted && !cs_n |=> aborted;
    endproperty
    // Shortest legal range is four bytes, so busy never stands briefly
    property p_busy_min;
        $rose(busy) |-> busy [*8];
    endproperty
    property p_sck_idle;
        cs_n |-> !sck;
    endproperty
    property p_sck_half;
        $rose(sck) |-> s_sck_pulse;
    endproperty
    property p_mosi_stable;
        sck && $past(sck) |-> $stable(mosi);
    endproperty

    a_start_at_cs: assert property (p_start_at_cs) else $error("busy rose inside a frame");
    a_busy_susp: assert property (p_busy_susp) else $error("busy while suspended");
    a_susp_from_run: assert property (p_susp_from_run) else $error("suspend while idle");
    a_resume_at_cs: assert property (p_resume_at_cs) else $error("bad resume");
    a_abort_idle: assert property (p_abort_idle) else $error("abort not idle");
    a_abort_sticky: assert property (p_abort_sticky) else $error("abort flag lost");
    a_busy_min: assert property (p_busy_min) else $error("calculation too short");
    a_sck_idle: assert property (p_sck_idle) else $error("clock moved outside frame");
    a_sck_half: assert property (p_sck_half) else $error("clock high time wrong");
    a_mosi_stable: assert property (p_mosi_stable) else $error("data moved, clock high");
endmodule

// ===== tb/flash_array_crc_check_tb_top.sv
// Testbench joining the flash device end and its host controller
`timescale 1ns/1ps
`include "fcrc_defs.svh"
module flash_array_crc_check_tb_top;
    logic hclk, hresetn, hwrite, hreadyout, hresp, irq, busy, suspended, aborted, arr_wr_en;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] arr_wr_addr, arr_wr_data;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    typedef struct {logic [7:0] s, e; logic a;} fcrc_row_t;
    fcrc_row_t rows[6] = '{'{8'h00, 8'h03, 1'b0}, '{8'h10, 8'h2F, 1'b0},
        '{8'h0A, 8'h0C, 1'b1}, '{8'hC8, 8'hFF, 1'b0}, '{8'h14, 8'h0A, 1'b1},
        '{8'h05, 8'h08, 1'b0}};

    fcrc_spi_if fcrc_spi_if_i();
    fcrc_device fcrc_device_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .spi(fcrc_spi_if_i.dev), .arr_wr_en(arr_wr_en), .arr_wr_addr(arr_wr_addr),
        .arr_wr_data(arr_wr_data), .busy(busy), .suspended(suspended), .aborted(aborted));
    fcrc_host fcrc_host_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq(irq), .spi(fcrc_spi_if_i.host));
    fcrc_assertions fcrc_assertions_i (.hclk(hclk), .hresetn(hresetn),
        .sck(fcrc_spi_if_i.sck), .cs_n(fcrc_spi_if_i.cs_n), .mosi(fcrc_spi_if_i.mosi),
        .miso(fcrc_spi_if_i.miso), .busy(busy), .suspended(suspended), .aborted(aborted));

    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    function automatic logic [7:0] pat(input int a);
        return 8'(a * 7 + 3);
    endfunction

    function automatic logic [31:0] crc_of(input logic [7:0] s, input logic [7:0] e);
        logic [31:0] c;
        c = `FCRC_INIT;
        for (int a = s; a <= e; a++)
        begin
            c = c ^ {pat(a), 24'h00_0000};
            for (int k = 0; k < 8; k++)
            begin
                c = c[31] ? ((c << 1) ^ `FCRC_POLY) : (c << 1);
            end
        end
        return c ^ `FCRC_XOROUT;
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check_value(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits ride on hready alone; the cycle ceiling below ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do
            @(posedge hclk);
        while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do
            @(posedge hclk);
        while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic frame(input logic [7:0] op, input logic [3:0] ntx, input logic [3:0] nrx);
        bus(1'b1, `FCRC_A_CMD, {16'h0000, nrx, ntx, op});
        rd = 32'h0000_0001;
        while (rd[0] !== 1'b0)
            bus(1'b0, `FCRC_A_STAT, 32'h0000_0000);
    endtask

    task automatic dev_read(input logic [31:0] a, input logic [7:0] op, input logic [3:0] n);
        bus(1'b1, `FCRC_A_TXLO, a);
        frame(op, 4'h4, n);
        bus(1'b0, `FCRC_A_RX, 32'h0000_0000);
    endtask

    task automatic start_check(input logic [7:0] s, input logic [7:0] e);
        bus(1'b1, `FCRC_A_TXLO, 32'(s));
        bus(1'b1, `FCRC_A_TXHI, 32'(e));
        frame(`FCRC_OP_CHECK, 4'h8, 4'h0);
    endtask

    task automatic wait_ready();
        rd = 32'h0000_0100;
        while (rd[8] !== 1'b0)
            dev_read(`FCRC_RA_STS1, `FCRC_OP_RDREG, 4'h2);
    endtask

    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 70000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        hresetn = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        arr_wr_en = 1'b0;
        arr_wr_addr = 8'h00;
        arr_wr_data = 8'h00;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        // Preloading also covers the device's synchroniser settling time
        for (int a = 0; a < 256; a++)
        begin
            @(posedge hclk);
            arr_wr_en <= 1'b1;
            arr_wr_addr <= 8'(a);
            arr_wr_data <= pat(a);
        end
        @(posedge hclk);
        arr_wr_en <= 1'b0;
        foreach (rows[i])
        begin
            bus(1'b0, 8'(i * 4 + 16), 32'h0000_0000);
            check_value(rd, 32'h0000_0000);
        end
        bus(1'b1, `FCRC_A_IRQEN, 32'h0000_0001);
        foreach (rows[i])
        begin
            start_check(rows[i].s, rows[i].e);
            bus(1'b0, `FCRC_A_IRQST, 32'h0000_0000);
            check_value(32'(irq), 32'h0000_0001);
            check_value(rd, {30'h0000_0000, rows[i].e < rows[i].s + 4, 1'b1});
            bus(1'b1, `FCRC_A_IRQCLR, 32'h0000_0003);
            // Long ranges are still running here; the status frames raise done again
            wait_ready();
            check_value({irq, hresp, rd[15:8]}, 32'h0000_0200);
            check_value(32'(rd[7:0]), {27'h000_0000, rows[i].a, 3'h0});
            check_value(32'(aborted), 32'(rows[i].a));
            if (!rows[i].a)
            begin
                dev_read(`FCRC_RA_CRC0, `FCRC_OP_RDREG, 4'h4);
                check_value({rd[7:0], rd[15:8], rd[23:16], rd[31:24]},
                    crc_of(rows[i].s, rows[i].e));
            end
        end
        start_check(8'h14, 8'h0A);
        frame(`FCRC_OP_SWRST, 4'h0, 4'h0);
        check_value(32'(aborted), 32'h0000_0000);
        bus(1'b1, `FCRC_A_IRQEN, 32'h0000_0000);
        bus(1'b0, `FCRC_A_IRQST, 32'h0000_0000);
        check_value({irq, rd[0]}, 32'h0000_0001);
        start_check(8'h00, 8'hFF);
        dev_read(`FCRC_RA_STS1, `FCRC_OP_RDREG, 4'h2);
        check_value({busy, rd[15:8]}, 32'h0000_0101);
        frame(`FCRC_OP_SUSP, 4'h0, 4'h0);
        dev_read(`FCRC_RA_STS1, `FCRC_OP_RDREG, 4'h2);
        check_value({suspended, rd[15:0]}, 32'h0001_0010);
        dev_read(32'h0000_0040, `FCRC_OP_RDARR, 4'h1);
        check_value(32'(rd[7:0]), 32'(pat(64)));
        start_check(8'h00, 8'h03);
        check_value({busy, suspended}, 32'h0000_0001);
        frame(`FCRC_OP_RESUME, 4'h0, 4'h0);
        check_value({busy, suspended}, 32'h0000_0002);
        wait_ready();
        dev_read(`FCRC_RA_CRC0, `FCRC_OP_RDREG, 4'h4);
        check_value({rd[7:0], rd[15:8], rd[23:16], rd[31:24]}, crc_of(8'h00, 8'hFF));
        start_check(8'h00, 8'hFF);
        hresetn <= 1'b0;
        @(posedge hclk);
        check_value({busy, hreadyout, irq}, 32'h0000_0000);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        check_value({hreadyout, fcrc_spi_if_i.cs_n, busy}, 32'h0000_0006);
        give_verdict();
    end
endmodule
